// file: hdl/buck_converter_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
module buck_converter_control_regs #(
   // Serial device address; value is arbitrary
   parameter logic [6:0] DEVICE_ADDR = 7'h2C
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        resetn,
   // Serial bus, open drain
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   // External enable pin
   input  wire logic        en_pin,
   // First converter controls
   output logic             first_run,
   output logic             first_force_pwm,
   output logic             first_discharge_on,
   output logic [11:0]      first_current_limit_ma,
   output logic             first_current_limit_reserved,
   output logic [13:0]      first_slew_uv_per_us,
   output logic             first_slew_reserved,
   output logic [11:0]      first_voltage_mv,
   output logic             first_voltage_reserved,
   // Second converter controls
   output logic             second_run,
   output logic             second_force_pwm,
   output logic             second_discharge_on,
   output logic [11:0]      second_current_limit_ma,
   output logic             second_current_limit_reserved,
   output logic [13:0]      second_slew_uv_per_us,
   output logic             second_slew_reserved,
   output logic [11:0]      second_voltage_mv,
   output logic             second_voltage_reserved
);

   typedef struct packed {
      buck_ctrl_pkg::serial_state_t st;
      logic [2:0]                   bitcnt;
      logic [7:0]                   shreg;
      logic [7:0]                   ptr;
      logic                         rw;
      logic                         pend;
      logic                         oe;
      logic                         scl_prev;
      logic                         sda_prev;
      logic [7:0]                   first_mode_enable;
      logic [7:0]                   first_limit_slew;
      logic [7:0]                   second_mode_enable;
      logic [7:0]                   second_limit_slew;
      logic [7:0]                   first_voltage;
      logic [7:0]                   second_voltage;
   } regs_t;

   regs_t      q, d;
   logic       scl_f;
   logic       sda_f;
   logic       en_f;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_cond;
   logic       stop_cond;
   logic [7:0] rd;
   logic [7:0] rx;

   // ==========================================================
   // Pin conditioning
   pin_filter #(.RESET_LEVEL(1'b1)) u_scl_filter (
      .clock  (clock),
      .resetn (resetn),
      .pin_in (scl_in),
      .level  (scl_f)
   );

   pin_filter #(.RESET_LEVEL(1'b1)) u_sda_filter (
      .clock  (clock),
      .resetn (resetn),
      .pin_in (sda_in),
      .level  (sda_f)
   );

   pin_filter #(.RESET_LEVEL(1'b0)) u_en_filter (
      .clock  (clock),
      .resetn (resetn),
      .pin_in (en_pin),
      .level  (en_f)
   );

   assign scl_rise   = scl_f & ~q.scl_prev;
   assign scl_fall   = ~scl_f & q.scl_prev;
   assign start_cond = scl_f & q.scl_prev & q.sda_prev & ~sda_f;
   assign stop_cond  = scl_f & q.scl_prev & ~q.sda_prev & sda_f;
   assign rx         = {q.shreg[6:0], sda_f};

   // ==========================================================
   // Read-back mux; reserved bits return what was written
   always_comb begin
      unique case (q.ptr)
         buck_ctrl_pkg::FIRST_MODE_ENABLE_OFS:  rd = q.first_mode_enable;
         buck_ctrl_pkg::FIRST_LIMIT_SLEW_OFS:   rd = q.first_limit_slew;
         buck_ctrl_pkg::SECOND_MODE_ENABLE_OFS: rd = q.second_mode_enable;
         buck_ctrl_pkg::SECOND_LIMIT_SLEW_OFS:  rd = q.second_limit_slew;
         buck_ctrl_pkg::FIRST_VOLTAGE_OFS:      rd = q.first_voltage;
         buck_ctrl_pkg::SECOND_VOLTAGE_OFS:     rd = q.second_voltage;
         default:                               rd = buck_ctrl_pkg::UNMAPPED_READ;
      endcase
   end

   // ==========================================================
   // Serial engine and register writes
   always_comb begin
      d          = q;
      d.scl_prev = scl_f;
      d.sda_prev = sda_f;
      if (start_cond) begin
         // Repeated start keeps the pointer for combined read
         d.st     = buck_ctrl_pkg::S_ADDR;
         d.bitcnt = 3'h0;
         d.pend   = 1'b0;
         d.oe     = 1'b0;
      end else if (stop_cond) begin
         d.st   = buck_ctrl_pkg::S_IDLE;
         d.pend = 1'b0;
         d.oe   = 1'b0;
      end else if (scl_rise) begin
         unique case (q.st)
            buck_ctrl_pkg::S_ADDR, buck_ctrl_pkg::S_PTR, buck_ctrl_pkg::S_WDATA: begin
               d.shreg  = rx;
               d.bitcnt = q.bitcnt + 3'h1;
               if (q.bitcnt == 3'h7) begin
                  d.pend = 1'b1;
                  if (q.st == buck_ctrl_pkg::S_ADDR) begin
                     d.rw = rx[0];
                     if (rx[7:1] != DEVICE_ADDR) begin
                        d.st   = buck_ctrl_pkg::S_IDLE;
                        d.pend = 1'b0;
                     end
                  end else if (q.st == buck_ctrl_pkg::S_PTR) begin
                     d.ptr = rx;
                  end else begin
                     d.ptr = q.ptr + 8'h01;
                     // Limit code takes effect at once, converter running or not
                     unique case (q.ptr)
                        buck_ctrl_pkg::FIRST_MODE_ENABLE_OFS:  d.first_mode_enable  = rx;
                        buck_ctrl_pkg::FIRST_LIMIT_SLEW_OFS:   d.first_limit_slew   = rx;
                        buck_ctrl_pkg::SECOND_MODE_ENABLE_OFS: d.second_mode_enable = rx;
                        buck_ctrl_pkg::SECOND_LIMIT_SLEW_OFS:  d.second_limit_slew  = rx;
                        buck_ctrl_pkg::FIRST_VOLTAGE_OFS:      d.first_voltage      = rx;
                        buck_ctrl_pkg::SECOND_VOLTAGE_OFS:     d.second_voltage     = rx;
                        default: begin
                        end
                     endcase
                  end
               end
            end
            buck_ctrl_pkg::S_RDATA: begin
               d.bitcnt = q.bitcnt + 3'h1;
               if (q.bitcnt == 3'h7) begin
                  d.pend = 1'b1;
               end
            end
            buck_ctrl_pkg::S_RDATA_ACK: begin
               // Master not-acknowledge ends the read burst
               if (sda_f) begin
                  d.st = buck_ctrl_pkg::S_IDLE;
               end else begin
                  d.pend = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         if (q.pend) begin
            d.pend = 1'b0;
            unique case (q.st)
               buck_ctrl_pkg::S_ADDR: begin
                  d.oe = 1'b1;
                  d.st = buck_ctrl_pkg::S_ADDR_ACK;
               end
               buck_ctrl_pkg::S_PTR: begin
                  d.oe = 1'b1;
                  d.st = buck_ctrl_pkg::S_PTR_ACK;
               end
               buck_ctrl_pkg::S_WDATA: begin
                  d.oe = 1'b1;
                  d.st = buck_ctrl_pkg::S_WDATA_ACK;
               end
               buck_ctrl_pkg::S_RDATA: begin
                  d.oe = 1'b0;
                  d.st = buck_ctrl_pkg::S_RDATA_ACK;
               end
               buck_ctrl_pkg::S_RDATA_ACK: begin
                  d.shreg  = rd;
                  d.ptr    = q.ptr + 8'h01;
                  d.oe     = ~rd[7];
                  d.bitcnt = 3'h0;
                  d.st     = buck_ctrl_pkg::S_RDATA;
               end
               default: begin
               end
            endcase
         end else begin
            unique case (q.st)
               buck_ctrl_pkg::S_ADDR_ACK: begin
                  d.bitcnt = 3'h0;
                  if (q.rw) begin
                     d.shreg = rd;
                     d.ptr   = q.ptr + 8'h01;
                     d.oe    = ~rd[7];
                     d.st    = buck_ctrl_pkg::S_RDATA;
                  end else begin
                     d.oe = 1'b0;
                     d.st = buck_ctrl_pkg::S_PTR;
                  end
               end
               buck_ctrl_pkg::S_PTR_ACK, buck_ctrl_pkg::S_WDATA_ACK: begin
                  d.oe     = 1'b0;
                  d.bitcnt = 3'h0;
                  d.st     = buck_ctrl_pkg::S_WDATA;
               end
               buck_ctrl_pkg::S_RDATA: begin
                  d.shreg = {q.shreg[6:0], 1'b0};
                  d.oe    = ~q.shreg[6];
               end
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         q                    <= '0;
         q.st                 <= buck_ctrl_pkg::S_IDLE;
         q.scl_prev           <= 1'b1;
         q.sda_prev           <= 1'b1;
         q.first_mode_enable  <= buck_ctrl_pkg::MODE_ENABLE_RST;
         q.first_limit_slew   <= buck_ctrl_pkg::LIMIT_SLEW_RST;
         q.second_mode_enable <= buck_ctrl_pkg::MODE_ENABLE_RST;
         q.second_limit_slew  <= buck_ctrl_pkg::LIMIT_SLEW_RST;
         q.first_voltage      <= buck_ctrl_pkg::FIRST_VOLTAGE_RST;
         q.second_voltage     <= buck_ctrl_pkg::SECOND_VOLTAGE_RST;
      end else begin
         q <= d;
      end
   end

   // Open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe  = q.oe;

   // ==========================================================
   // Converter decode; voltage ranges in the shared decoder
   // cover the 5 mV and 20 mV segments as well
   converter_outputs u_first (
      .clock                  (clock),
      .resetn                 (resetn),
      .mode_enable            (q.first_mode_enable),
      .limit_slew             (q.first_limit_slew),
      .voltage                (q.first_voltage),
      .en_pin                 (en_f),
      .run                    (first_run),
      .force_pwm              (first_force_pwm),
      .discharge_on           (first_discharge_on),
      .current_limit_ma       (first_current_limit_ma),
      .current_limit_reserved (first_current_limit_reserved),
      .slew_uv_per_us         (first_slew_uv_per_us),
      .slew_reserved          (first_slew_reserved),
      .voltage_mv             (first_voltage_mv),
      .voltage_reserved       (first_voltage_reserved)
   );

   converter_outputs u_second (
      .clock                  (clock),
      .resetn                 (resetn),
      .mode_enable            (q.second_mode_enable),
      .limit_slew             (q.second_limit_slew),
      .voltage                (q.second_voltage),
      .en_pin                 (en_f),
      .run                    (second_run),
      .force_pwm              (second_force_pwm),
      .discharge_on           (second_discharge_on),
      .current_limit_ma       (second_current_limit_ma),
      .current_limit_reserved (second_current_limit_reserved),
      .slew_uv_per_us         (second_slew_uv_per_us),
      .slew_reserved          (second_slew_reserved),
      .voltage_mv             (second_voltage_mv),
      .voltage_reserved       (second_voltage_reserved)
   );

endmodule // buck_converter_control_regs
`default_nettype wire

// file: hdl/buck_ctrl_pkg.sv
`default_nettype none
package buck_ctrl_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] FIRST_MODE_ENABLE_OFS  = 8'h02;
   localparam logic [7:0] FIRST_LIMIT_SLEW_OFS   = 8'h03;
   localparam logic [7:0] SECOND_MODE_ENABLE_OFS = 8'h04;
   localparam logic [7:0] SECOND_LIMIT_SLEW_OFS  = 8'h05;
   localparam logic [7:0] FIRST_VOLTAGE_OFS      = 8'h06;
   localparam logic [7:0] SECOND_VOLTAGE_OFS     = 8'h07;
   localparam logic [7:0] UNMAPPED_READ          = 8'h00;

   // ==========================================================
   // Reset values
   localparam logic [7:0] MODE_ENABLE_RST   = 8'h07;
   localparam logic [7:0] LIMIT_SLEW_RST    = 8'h2A;
   localparam logic [7:0] FIRST_VOLTAGE_RST  = 8'h6B;
   localparam logic [7:0] SECOND_VOLTAGE_RST = 8'h59;

   // ==========================================================
   // Field positions
   localparam int FPWM_BIT    = 3;
   localparam int RDIS_BIT    = 2;
   localparam int PIN_SEL_BIT = 1;
   localparam int EN_BIT      = 0;
   localparam int ILIM_LSB    = 3;
   localparam int SLEW_LSB    = 0;

   // ==========================================================
   // Code ranges
   localparam logic [2:0] ILIM_MAX_CODE  = 3'h5;
   localparam logic [2:0] SLEW_MIN_CODE  = 3'h2;
   localparam logic [7:0] VOUT_FINE_LO   = 8'h14;
   localparam logic [7:0] VOUT_MID_LO    = 8'h18;
   localparam logic [7:0] VOUT_COARSE_LO = 8'h9E;

   // ==========================================================
   // Serial engine states
   typedef enum logic [8:0] {
      S_IDLE      = 9'h001,
      S_ADDR      = 9'h002,
      S_ADDR_ACK  = 9'h004,
      S_PTR       = 9'h008,
      S_PTR_ACK   = 9'h010,
      S_WDATA     = 9'h020,
      S_WDATA_ACK = 9'h040,
      S_RDATA     = 9'h080,
      S_RDATA_ACK = 9'h100
   } serial_state_t;

   // ==========================================================
   // Decoders; reserved codes give zero
   function automatic logic [11:0] limit_ma(input logic [2:0] c);
      limit_ma = (c <= ILIM_MAX_CODE) ? 12'(1500 + 500 * int'(c)) : 12'h000;
   endfunction

   function automatic logic [13:0] slew_uv(input logic [2:0] c);
      case (c)
         3'h2:    slew_uv = 14'(10000);
         3'h3:    slew_uv = 14'(7500);
         3'h4:    slew_uv = 14'(3800);
         3'h5:    slew_uv = 14'(1900);
         3'h6:    slew_uv = 14'(940);
         3'h7:    slew_uv = 14'(470);
         default: slew_uv = 14'h0000;
      endcase
   endfunction

   function automatic logic [11:0] vout_mv(input logic [7:0] c);
      if (c >= VOUT_COARSE_LO)
         vout_mv = 12'(1420 + 20 * int'(c - VOUT_COARSE_LO));
      else if (c >= VOUT_MID_LO)
         vout_mv = 12'(735 + 5 * int'(c - VOUT_MID_LO));
      else if (c >= VOUT_FINE_LO)
         vout_mv = 12'(700 + 10 * int'(c - VOUT_FINE_LO));
      else
         vout_mv = 12'h000;
   endfunction

endpackage
`default_nettype wire

// file: hdl/converter_outputs.sv
`timescale 1ns/1ps
`default_nettype none
module converter_outputs (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        resetn,
   // Register contents and enable pin level
   input  wire logic [7:0]  mode_enable,
   input  wire logic [7:0]  limit_slew,
   input  wire logic [7:0]  voltage,
   input  wire logic        en_pin,
   // Analog controls
   output logic             run,
   output logic             force_pwm,
   output logic             discharge_on,
   output logic [11:0]      current_limit_ma,
   output logic             current_limit_reserved,
   output logic [13:0]      slew_uv_per_us,
   output logic             slew_reserved,
   output logic [11:0]      voltage_mv,
   output logic             voltage_reserved
);

   typedef struct packed {
      logic        run;
      logic        fpwm;
      logic        dis;
      logic [11:0] ilim;
      logic        ilim_rsv;
      logic [13:0] slew;
      logic        slew_rsv;
      logic [11:0] mv;
      logic        mv_rsv;
   } conv_t;

   conv_t      q, d;
   logic [2:0] ilim_code;
   logic [2:0] slew_code;

   assign ilim_code = limit_slew[buck_ctrl_pkg::ILIM_LSB +: 3];
   assign slew_code = limit_slew[buck_ctrl_pkg::SLEW_LSB +: 3];

   // ==========================================================
   // Decode; follows register writes every cycle, no enable gating
   always_comb begin
      d          = q;
      d.run      = mode_enable[buck_ctrl_pkg::EN_BIT] &
                   (~mode_enable[buck_ctrl_pkg::PIN_SEL_BIT] | en_pin);
      d.fpwm     = mode_enable[buck_ctrl_pkg::FPWM_BIT];
      d.dis      = ~d.run & mode_enable[buck_ctrl_pkg::RDIS_BIT];
      d.ilim     = buck_ctrl_pkg::limit_ma(ilim_code);
      d.ilim_rsv = ilim_code > buck_ctrl_pkg::ILIM_MAX_CODE;
      // One rate drives both ramp directions
      d.slew     = buck_ctrl_pkg::slew_uv(slew_code);
      d.slew_rsv = slew_code < buck_ctrl_pkg::SLEW_MIN_CODE;
      d.mv       = buck_ctrl_pkg::vout_mv(voltage);
      d.mv_rsv   = voltage < buck_ctrl_pkg::VOUT_FINE_LO;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign run                    = q.run;
   assign force_pwm              = q.fpwm;
   assign discharge_on           = q.dis;
   assign current_limit_ma       = q.ilim;
   assign current_limit_reserved = q.ilim_rsv;
   assign slew_uv_per_us         = q.slew;
   assign slew_reserved          = q.slew_rsv;
   assign voltage_mv             = q.mv;
   assign voltage_reserved       = q.mv_rsv;

endmodule // converter_outputs
`default_nettype wire

// file: hdl/pin_filter.sv
`timescale 1ns/1ps
`default_nettype none
module pin_filter #(
   parameter logic RESET_LEVEL = 1'b1
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic resetn,
   // Pin and filtered level
   input  wire logic pin_in,
   output logic      level
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } filt_t;

   filt_t q, d;

   // ==========================================================
   // Level moves only once two later stages agree
   always_comb begin
      d     = q;
      d.s1  = pin_in;
      d.s2  = q.s1;
      d.s3  = q.s2;
      if (q.s2 == q.s3) begin
         d.lvl = q.s3;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         q <= {4{RESET_LEVEL}};
      end else begin
         q <= d;
      end
   end

   assign level = q.lvl;

endmodule // pin_filter
`default_nettype wire

// file: tb/buck_converter_control_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module buck_converter_control_regs_test;
   // Device address; value is arbitrary
   localparam logic [6:0] ADDR = 7'h2C;
   logic        clock, resetn, en_pin, scl_in, sda_in, sda_out, sda_oe, sda_drv, ack;
   logic        first_run, first_force_pwm, first_discharge_on, first_current_limit_reserved;
   logic        second_run, second_force_pwm, second_discharge_on, second_current_limit_reserved;
   logic        first_slew_reserved, first_voltage_reserved;
   logic        second_slew_reserved, second_voltage_reserved;
   logic [11:0] first_current_limit_ma, first_voltage_mv, second_current_limit_ma, second_voltage_mv;
   logic [13:0] first_slew_uv_per_us, second_slew_uv_per_us;
   logic [7:0]  rv, v;
   logic [7:0]  vt[8] = '{8'h00, 8'h13, 8'h14, 8'h17, 8'h18, 8'h9D, 8'h9E, 8'hFF};
   int          m[256];
   int          slew[8] = '{0, 0, 10000, 7500, 3800, 1900, 940, 470};
   int          seed = 32'h8D5F;
   int          comparisons = 0;
   int          miscompares = 0;

   assign sda_in = sda_drv & ~sda_oe;
   buck_converter_control_regs #(.DEVICE_ADDR(ADDR)) u_dut (.clock, .resetn, .scl_in, .sda_in,
      .sda_out, .sda_oe, .en_pin, .first_run, .first_force_pwm, .first_discharge_on,
      .first_current_limit_ma, .first_current_limit_reserved, .first_slew_uv_per_us,
      .first_slew_reserved, .first_voltage_mv, .first_voltage_reserved, .second_run,
      .second_force_pwm, .second_discharge_on, .second_current_limit_ma,
      .second_current_limit_reserved, .second_slew_uv_per_us, .second_slew_reserved,
      .second_voltage_mv, .second_voltage_reserved);
   serial_host u_host (.clock, .sda(sda_in), .scl(scl_in), .sda_drv);

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // ======
   // Checking and model
   task automatic chk(input logic [63:0] seen, input logic [63:0] want);
      comparisons++;
      if (seen !== want) begin
         miscompares++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, want);
      end
   endtask
   function automatic logic [43:0] dec(int c, int l, int v);
      int   il;
      int   sl;
      int   mv;
      logic run;
      il = (l >> 3) & 7;
      sl = l & 7;
      run = c[0] && (!c[1] || en_pin);
      if (v >= 8'h9E)
         mv = 1420 + 20 * (v - 8'h9E);
      else if (v >= 8'h18)
         mv = 735 + 5 * (v - 8'h18);
      else if (v >= 8'h14)
         mv = 700 + 10 * (v - 8'h14);
      else
         mv = 0;
      return {run, c[3], !run && c[2], 12'(il <= 5 ? 1500 + 500 * il : 0), il > 5,
              14'(slew[sl]), sl < 2, 12'(mv), v < 8'h14};
   endfunction
   task automatic chk_outs();
      chk(64'({first_run, first_force_pwm, first_discharge_on, first_current_limit_ma,
         first_current_limit_reserved, first_slew_uv_per_us, first_slew_reserved,
         first_voltage_mv, first_voltage_reserved}), 64'(dec(m[2], m[3], m[6])));
      chk(64'({second_run, second_force_pwm, second_discharge_on, second_current_limit_ma,
         second_current_limit_reserved, second_slew_uv_per_us, second_slew_reserved,
         second_voltage_mv, second_voltage_reserved}), 64'(dec(m[4], m[5], m[7])));
   endtask
   // ======
   // Register access
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      u_host.start();
      u_host.xfer({ADDR, 1'b0}, 1'b1, rv, ack);
      chk(64'(ack), 64'h0);
      u_host.xfer(p, 1'b1, rv, ack);
      u_host.xfer(d, 1'b1, rv, ack);
      u_host.stop();
      if (p >= 2 && p <= 7)
         m[p] = d;
      chk_outs();
   endtask
   task automatic rd(input logic [7:0] p, input int n);
      u_host.start();
      u_host.xfer({ADDR, 1'b0}, 1'b1, rv, ack);
      u_host.xfer(p, 1'b1, rv, ack);
      u_host.start();
      u_host.xfer({ADDR, 1'b1}, 1'b1, rv, ack);
      for (int i = 0; i < n; i++) begin
         u_host.xfer(8'hFF, 1'(i == n - 1), rv, ack);
         chk(64'(rv), 64'(m[p + i]));
      end
      u_host.stop();
   endtask
   task automatic finish_test();
      $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // ======
   // Tests
   initial begin
      en_pin = 1'b0;
      resetn = 1'b0;
      repeat (2) @(posedge clock);
      #1;
      resetn = 1'b1;
      for (int i = 2; i < 8; i++) m[i] = (i == 6) ? 8'h6B : (i == 7) ? 8'h59 : i[0] ? 8'h2A : 8'h07;
      repeat (6) @(posedge clock);
      #1;
      chk_outs();
      rd(8'h02, 6);
      $display("defaults test done");
      // Limit changes land while the first converter runs
      wr(8'h02, 8'h01);
      for (int i = 0; i < 8; i++) begin
         wr(8'h03, {2'($random(seed)), 3'(i), 3'(7 - i)});
         wr(8'h05, {2'($random(seed)), 3'(7 - i), 3'(i)});
      end
      $display("limit and slew test done");
      for (int i = 0; i < 16; i++) begin
         en_pin = 1'($random(seed));
         wr(8'h02, {4'($random(seed)), 4'(i)});
         wr(8'h04, {4'($random(seed)), 4'(15 - i)});
      end
      $display("mode and enable test done");
      for (int i = 0; i < 12; i++) begin
         v = i < 8 ? vt[i] : 8'($random(seed));
         wr(8'h06, v);
         wr(8'h07, ~v);
      end
      $display("voltage test done");
      wr(8'h10, 8'h5A);
      rd(8'h10, 1);
      u_host.start();
      u_host.xfer({ADDR ^ 7'h01, 1'b0}, 1'b1, rv, ack);
      chk(64'(ack), 64'h1);
      u_host.stop();
      rd(8'h02, 6);
      $display("access test done");
      finish_test();
   end
   initial begin
      repeat (100000) @(posedge clock);
      miscompares++;
      finish_test();
   end
endmodule // buck_converter_control_regs_test
`default_nettype wire

// file: tb/buck_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module buck_regs_monitor (
   // Clock, reset and serial pins
   input wire logic        clock,
   input wire logic        resetn,
   input wire logic        scl_in,
   input wire logic        sda_out,
   input wire logic        sda_oe,
   // First converter
   input wire logic        first_run,
   input wire logic        first_discharge_on,
   input wire logic [11:0] first_current_limit_ma,
   input wire logic        first_current_limit_reserved,
   input wire logic [13:0] first_slew_uv_per_us,
   input wire logic        first_slew_reserved,
   input wire logic [11:0] first_voltage_mv,
   input wire logic        first_voltage_reserved
);
   // ======
   // Decode outputs still hold zeros on the first edge after release
   logic live_q;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         live_q <= 1'b0;
      else
         live_q <= 1'b1;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // ======
   // Decode checks
   limit_zero_a: assert property (live_q && first_current_limit_reserved |->
      first_current_limit_ma == 12'h000) else $error("reserved limit not zero");
   limit_step_a: assert property (live_q && !first_current_limit_reserved |->
      first_current_limit_ma inside {1500, 2000, 2500, 3000, 3500, 4000})
      else $error("limit value off grid");
   slew_value_a: assert property (live_q |-> (first_slew_reserved ? first_slew_uv_per_us == 0 :
      first_slew_uv_per_us inside {10000, 7500, 3800, 1900, 940, 470})) else $error("bad slew");
   vout_zero_a: assert property (live_q && first_voltage_reserved |->
      first_voltage_mv == 12'h000) else $error("reserved voltage not zero");
   vout_fine_a: assert property (live_q && !first_voltage_reserved && first_voltage_mv < 735 |->
      first_voltage_mv >= 700 && first_voltage_mv % 10 == 0) else $error("fine step off");
   vout_coarse_a: assert property (first_voltage_mv > 1400 |-> first_voltage_mv >= 1420 &&
      first_voltage_mv <= 3360 && (first_voltage_mv - 1420) % 20 == 0) else $error("coarse off");
   discharge_off_a: assert property (first_run && $past(first_run) |-> !first_discharge_on)
      else $error("discharge while running");
   // ======
   // Serial pin checks
   ack_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*8]) else $error("pull too short");
   edge_safe_a: assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved, clock high");
   open_drain_a: assert property (sda_out == 1'b0) else $error("data pin driven high");
endmodule // buck_regs_monitor

bind buck_converter_control_regs buck_regs_monitor u_mon (.clock, .resetn, .scl_in, .sda_out,
   .sda_oe, .first_run, .first_discharge_on, .first_current_limit_ma,
   .first_current_limit_reserved, .first_slew_uv_per_us, .first_slew_reserved,
   .first_voltage_mv, .first_voltage_reserved);
`default_nettype wire

// file: tb/serial_host.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host (
   // Clock and resolved data line
   input  wire logic clock,
   input  wire logic sda,
   // Driven pins; a released data line reads high through the pull-up
   output logic      scl,
   output logic      sda_drv
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // ======
   // Ten clocks per phase keeps well clear of the pin filter latency
   task automatic hp();
      repeat (10) @(posedge clock);
      #1;
   endtask
   task automatic start();
      sda_drv = 1'b1;
      hp();
      scl = 1'b1;
      hp();
      sda_drv = 1'b0;
      hp();
      scl = 1'b0;
   endtask
   task automatic stop();
      sda_drv = 1'b0;
      hp();
      scl = 1'b1;
      hp();
      sda_drv = 1'b1;
      hp();
   endtask
   // Eight bits then the acknowledge slot; data moves only while the clock is low
   task automatic xfer(input logic [7:0] w, input logic ack, output logic [7:0] r,
                       output logic got);
      for (int i = 8; i >= 0; i--) begin
         sda_drv = (i == 0) ? ack : w[i - 1];
         hp();
         scl = 1'b1;
         hp();
         if (i > 0)
            r[i - 1] = sda;
         else
            got = sda;
         scl = 1'b0;
      end
   endtask
endmodule // serial_host
`default_nettype wire
